// >>> rtl/sample_fifo.sv
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             clr,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);
  wire              push  = in_valid && !full;
  wire              load  = !empty && (!out_valid_q || out_ready);

  assign in_ready  = !full;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  // Storage writes
  always_ff @(posedge clk)
  begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end

  // Pointers and output register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q        <= '0;
      rd_q        <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end
    else if (clr)
    begin
      wr_q        <= '0;
      rd_q        <= '0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      if (push) wr_q <= wr_q + 1'b1;
      if (load)
      begin
        out_data_q  <= mem_q[rd_q[AW-1:0]];
        rd_q        <= rd_q + 1'b1;
        out_valid_q <= 1'b1;
      end
      else if (out_ready) out_valid_q <= 1'b0;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// >>> rtl/scope_capture_decimator.sv
// Two-channel decimating ring capture with triggered posttrigger count and host readout
`timescale 1ns/1ps
`default_nettype none
module scope_capture_decimator
  import scope_pkg::*;
#(
  parameter int DEPTH   = scope_pkg::MEM_DEPTH,
  parameter int DECIM_B = scope_pkg::DECIM_W
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire scope_pkg::sample_pair_t    adc_data,
  input  wire logic                       trig_pin,
  input  wire logic                       arm,
  input  wire logic                       force_stop,
  input  wire logic [DECIM_B-1:0]         decim_factor,
  input  wire logic [scope_pkg::ADDR_W:0] post_count,
  input  wire logic [scope_pkg::ADDR_W:0] record_len,
  input  wire logic                       read_start,
  input  wire scope_pkg::front_ctrl_t     front_cfg,
  output scope_pkg::front_ctrl_t          front_out,
  output logic                            armed,
  output logic                            triggered,
  output logic                            capture_done,
  output logic                            config_error,
  output logic [scope_pkg::ADDR_W-1:0]    oldest_ptr,
  output scope_pkg::sample_pair_t         rd_data,
  output logic                            rd_valid,
  input  wire logic                       rd_ready,
  output logic                            read_busy
);
  initial
  begin
    if (DEPTH != MEM_DEPTH) $error("DEPTH must equal the address space of ADDR_W");
    if (DECIM_B < 1) $error("DECIM_B must be at least 1");
  end

  // Trigger pin synchroniser and edge detector
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= trig_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  wire trig_edge = trig_s2_q && !trig_s3_q;

  // Converter samples pass two flip-flops before use
  sample_pair_t adc_s1_q;
  sample_pair_t adc_s2_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      adc_s1_q <= '0;
      adc_s2_q <= '0;
    end
    else
    begin
      adc_s1_q <= adc_data;
      adc_s2_q <= adc_s1_q;
    end
  end

  // True when a sample count fits in one channel's memory
  function automatic logic fits_depth(input logic [ADDR_W:0] v);
    return v <= (ADDR_W+1)'(DEPTH);
  endfunction : fits_depth

  // True when a count has reached the full memory depth
  function automatic logic at_depth(input logic [ADDR_W:0] v);
    return v == (ADDR_W+1)'(DEPTH);
  endfunction : at_depth

  // Configuration legality checks
  wire decim_ok = (decim_factor != '0);
  wire post_ok  = fits_depth(post_count);
  wire len_ok   = (record_len != '0) && fits_depth(record_len);
  wire cfg_ok   = decim_ok && post_ok && len_ok;
  assign config_error = !cfg_ok;

  // Decimation divider: one keep pulse every N raw samples
  logic [DECIM_B-1:0] dec_cnt_q;
  cap_state_t         state_q;
  wire                dec_wrap = (dec_cnt_q >= decim_factor - 1'b1);
  wire                keep     = (state_q == ST_ARMED || state_q == ST_POST) && dec_wrap;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) dec_cnt_q <= '0;
    else if (state_q == ST_IDLE || dec_wrap) dec_cnt_q <= '0;
    else dec_cnt_q <= dec_cnt_q + 1'b1;
  end

  // Capture pointers and counters
  logic [ADDR_W-1:0] wr_ptr_q;
  logic [ADDR_W:0]   post_left_q;
  logic [ADDR_W:0]   fill_q;
  logic [ADDR_W:0]   rd_left_q;
  logic [ADDR_W:0]   out_left_q;  // Words still to hand to the host
  logic [ADDR_W-1:0] rd_ptr_q;
  logic              done_q;
  logic              trig_q;
  logic              fifo_ready;
  wire               go        = arm && cfg_ok && (state_q == ST_IDLE);
  wire               post_last = keep && (post_left_q == (ADDR_W+1)'(1));
  wire               stop_now  = (state_q == ST_POST) && (post_left_q == '0 || post_last);
  wire               mem_rd    = (state_q == ST_READ) && (rd_left_q != '0) && fifo_ready;
  wire               read_go   = done_q && read_start && (state_q == ST_IDLE);
  wire               rd_take   = rd_valid && rd_ready;
  // Readout starts so that the last record_len samples end at the newest one
  wire [ADDR_W-1:0]  rd_start  = wr_ptr_q - record_len[ADDR_W-1:0];

  // Capture state machine
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q     <= ST_IDLE;
      wr_ptr_q    <= '0;
      post_left_q <= '0;
      fill_q      <= '0;
      done_q      <= 1'b0;
      trig_q      <= 1'b0;
      rd_left_q   <= '0;
      out_left_q  <= '0;
      rd_ptr_q    <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            state_q  <= ST_ARMED;
            wr_ptr_q <= '0;
            fill_q   <= '0;
            done_q   <= 1'b0;
            trig_q   <= 1'b0;
          end
          else if (read_go)
          begin
            state_q   <= ST_READ;
            rd_ptr_q  <= rd_start;
            rd_left_q  <= record_len;
            out_left_q <= record_len;
          end
        end
        ST_ARMED:
        begin
          if (keep)
          begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
            if (!at_depth(fill_q)) fill_q <= fill_q + 1'b1;
          end
          if (force_stop)
          begin
            state_q <= ST_IDLE;
          end
          else if (trig_edge)
          begin
            trig_q      <= 1'b1;
            post_left_q <= post_count;
            state_q     <= ST_POST;
          end
        end
        ST_POST:
        begin
          if (keep && post_left_q != '0)
          begin
            wr_ptr_q    <= wr_ptr_q + 1'b1;
            post_left_q <= post_left_q - 1'b1;
          end
          if (stop_now)
          begin
            state_q <= ST_IDLE;
            done_q  <= 1'b1;
          end
          else if (force_stop) state_q <= ST_IDLE;
        end
        ST_READ:
        begin
          if (mem_rd)
          begin
            rd_ptr_q  <= rd_ptr_q + 1'b1;
            rd_left_q <= rd_left_q - 1'b1;
          end
          if (rd_take) out_left_q <= out_left_q - 1'b1;
          // Stay busy until the last word has left the FIFO
          if (out_left_q == '0) state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture memories, one per channel, ring addressed
  logic [SAMPLE_W-1:0] mem0 [DEPTH];
  logic [SAMPLE_W-1:0] mem1 [DEPTH];
  wire                 mem_wr = keep && (state_q == ST_ARMED || post_left_q != '0);
  sample_pair_t        mem_q;
  logic                mem_valid_q;
  always_ff @(posedge clk)
  begin
    if (mem_wr)
    begin
      mem0[wr_ptr_q] <= adc_s2_q.ch0;
      mem1[wr_ptr_q] <= adc_s2_q.ch1;
    end
    if (mem_rd)
    begin
      mem_q.ch0 <= mem0[rd_ptr_q];
      mem_q.ch1 <= mem1[rd_ptr_q];
    end
  end

  // Read data valid one cycle after the memory read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) mem_valid_q <= 1'b0;
    else mem_valid_q <= mem_rd;
  end

  // Readout FIFO; a memory read waits until the previous word has been pushed,
  // so a word in flight always finds a free slot
  logic fifo_in_ready;
  assign fifo_ready = fifo_in_ready && !mem_valid_q;

  sample_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .clr       (go),
    .in_data   (mem_q),
    .in_valid  (mem_valid_q),
    .in_ready  (fifo_in_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  // Front-end static controls, a range outside its ten settings is ignored and the last one held
  front_ctrl_t front_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      front_q.range_sel  <= RANGE_RESET;
      front_q.offset_val <= OFFSET_RESET;
      front_q.filter_en  <= 1'b0;
    end
    else
    begin
      if (front_cfg.range_sel < RANGE_W'(RANGE_COUNT)) front_q.range_sel <= front_cfg.range_sel;
      front_q.offset_val <= front_cfg.offset_val;
      front_q.filter_en  <= front_cfg.filter_en;
    end
  end

  // Status outputs
  assign front_out    = front_q;
  assign armed        = (state_q == ST_ARMED) || (state_q == ST_POST);
  assign triggered    = trig_q;
  assign capture_done = done_q;
  assign oldest_ptr   = at_depth(fill_q) ? wr_ptr_q : '0;
  assign read_busy    = (state_q == ST_READ) || rd_valid;
endmodule : scope_capture_decimator
`default_nettype wire

// >>> rtl/scope_pkg.sv
// Shared constants and carrier types for the scope capture block
package scope_pkg;
  localparam int          SAMPLE_W      = 8;
  localparam int          MEM_DEPTH     = 16384;
  localparam int          ADDR_W        = 14;
  localparam int          DECIM_W       = 16;
  localparam int          RANGE_W       = 4;
  localparam int          RANGE_COUNT   = 10;
  localparam int          OFFSET_W      = 12;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          CLK_RATE_MSPS = 100;
  localparam logic [15:0] DECIM_RESET   = 16'h0001;
  localparam logic [3:0]  RANGE_RESET   = 4'h0;
  localparam logic [11:0] OFFSET_RESET  = 12'h000;

  typedef struct packed {
    logic [SAMPLE_W-1:0] ch0;
    logic [SAMPLE_W-1:0] ch1;
  } sample_pair_t;

  typedef struct packed {
    logic [RANGE_W-1:0]  range_sel;
    logic [OFFSET_W-1:0] offset_val;
    logic                filter_en;
  } front_ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST, ST_READ} cap_state_t;
endpackage : scope_pkg

// >>> test/adc_model.sv
// Converter front end model: ramp samples on both channels and a trigger pulser
`timescale 1ns/1ps
`default_nettype none
module adc_model
  import scope_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               fire,
  output scope_pkg::sample_pair_t adc_data,
  output logic                    trig_pin
);
  logic [7:0] cnt_q;
  logic [2:0] hold_q;
  // New sample pair every clock, ch1 is the inverse of ch0
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  assign adc_data = '{ch0: cnt_q, ch1: ~cnt_q};
  // Trigger held high for four cycles per request
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) hold_q <= 3'h0;
    else if (fire) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  assign trig_pin = (hold_q != 3'h0);
endmodule : adc_model
`default_nettype wire

// >>> test/scope_chk.sv
// Port-level checker for the scope capture block
`timescale 1ns/1ps
`default_nettype none
module scope_chk
  import scope_pkg::*;
#(
  parameter int DEPTH   = scope_pkg::MEM_DEPTH,
  parameter int DECIM_B = scope_pkg::DECIM_W
) (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   arm,
  input wire logic                   force_stop,
  input wire logic                   read_start,
  input wire scope_pkg::front_ctrl_t front_cfg,
  input wire scope_pkg::front_ctrl_t front_out,
  input wire logic                   armed,
  input wire logic                   capture_done,
  input wire logic                   config_error,
  input wire scope_pkg::sample_pair_t rd_data,
  input wire logic                   rd_valid,
  input wire logic                   rd_ready,
  input wire logic                   read_busy
);
  logic idle;
  // Neither capturing nor reading
  assign idle = !armed && !read_busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Readout steps
  sequence s_stall; rd_valid && !rd_ready; endsequence
  sequence s_go; read_start && capture_done && idle; endsequence
  a_arm_taken: assert property (arm && idle && !config_error && !force_stop |=> armed)
    else $error("arm not taken");
  a_cfg_refuse: assert property (config_error && idle |=> !armed)
    else $error("illegal config armed");
  a_rd_hold: assert property (s_stall |=> rd_valid && $stable(rd_data))
    else $error("read word dropped under stall");
  a_read_answer: assert property (s_go |-> ##[3:20] rd_valid)
    else $error("readout never started");
  a_read_refused: assert property (read_start && !capture_done && idle |=> !read_busy)
    else $error("readout without capture");
  a_done_stands: assert property (capture_done && !arm |=> capture_done)
    else $error("done flag lost");
  a_done_stops: assert property ($rose(capture_done) |-> !armed)
    else $error("still armed at done");
  a_stop_abort: assert property (armed && force_stop |=> !armed && !capture_done)
    else $error("abort failed");
  a_range_legal: assert property (front_out.range_sel < RANGE_COUNT)
    else $error("range out of set");
  a_range_hold: assert property (front_cfg.range_sel >= RANGE_COUNT |=> $stable(front_out.range_sel))
    else $error("illegal range taken");
  a_front_copy: assert property ($past(arst_n) |-> front_out.offset_val == $past(front_cfg.offset_val)
    && front_out.filter_en == $past(front_cfg.filter_en))
    else $error("front controls not copied");
endmodule : scope_chk
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the scope capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scope_pkg::*;
  logic clk, arst_n, fire, trig_pin, arm, force_stop, read_start, rd_ready;
  logic armed, triggered, capture_done, config_error, rd_valid, read_busy;
  logic [15:0] decim_factor;
  logic [14:0] post_count, record_len;
  logic [13:0] oldest_ptr;
  sample_pair_t adc_data, rd_data;
  front_ctrl_t front_cfg, front_out;
  int n_errors, compares;
  adc_model adc_model_i (.clk(clk), .arst_n(arst_n), .fire(fire), .adc_data(adc_data), .trig_pin(trig_pin));
  scope_capture_decimator scope_capture_decimator_i (.clk(clk), .arst_n(arst_n), .adc_data(adc_data),
    .trig_pin(trig_pin), .arm(arm), .force_stop(force_stop), .decim_factor(decim_factor),
    .post_count(post_count), .record_len(record_len), .read_start(read_start), .front_cfg(front_cfg),
    .front_out(front_out), .armed(armed), .triggered(triggered), .capture_done(capture_done),
    .config_error(config_error), .oldest_ptr(oldest_ptr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .read_busy(read_busy));
  // Clock, 100 ns period
  always #50 clk = ~clk;
  task tick(input int n); repeat (n) @(posedge clk); #1; endtask : tick
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task wrap_up;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Arm, wait, trigger, then wait for done
  task capture(input int n, input int post, input int pre);
    int c;
    decim_factor = n[15:0]; post_count = post[14:0]; arm = 1; tick(1); arm = 0;
    cmp(armed, 1);
    tick(pre); fire = 1; tick(1); fire = 0; c = 0;
    while (capture_done !== 1'b1 && c < 40000) begin tick(1); c++; end
    if (c >= 40000) begin n_errors++; wrap_up(); end
    cmp(c >= post * n, 1);
    cmp(c <= post * n + 12, 1);
    cmp(armed, 0);
    cmp(triggered, 1);
  endtask : capture
  // Read a record with an initial stall, check pairing, step and count
  task read_out(input int len, input logic [7:0] n, input int stall);
    int cnt, w;
    logic [7:0] prev, d, inv;
    record_len = len[14:0]; read_start = 1; tick(1); read_start = 0; cnt = 0; w = 0;
    while ((read_busy === 1'b1 || rd_valid === 1'b1) && w < 40000)
    begin
      rd_ready = (w >= stall);
      if (rd_valid === 1'b1 && rd_ready)
      begin
        inv = ~rd_data.ch0; d = rd_data.ch0 - prev;
        cmp(rd_data.ch1, inv);
        if (cnt > 0) cmp(d, n);
        prev = rd_data.ch0; cnt++;
      end
      tick(1); w++;
    end
    if (w >= 40000) begin n_errors++; wrap_up(); end
    rd_ready = 0;
    cmp(cnt, len);
  endtask : read_out
  initial
  begin
    clk = 0; arst_n = 0; fire = 0; arm = 0; force_stop = 0; read_start = 0; rd_ready = 0;
    decim_factor = 16'h0001; post_count = 15'h0000; record_len = 15'h0008; front_cfg = '0;
    n_errors = 0; compares = 0;
    repeat (6) @(posedge clk);
    #1 arst_n = 1;
    for (int i = 0; i < 12; i++)
    begin
      front_cfg = '{range_sel: i[3:0], offset_val: 12'h5A0 + i[11:0], filter_en: i[0]}; tick(2);
      cmp(front_out.range_sel, (i < 10) ? i : 9);
      cmp(front_out.offset_val, 12'h5A0 + i);
      cmp(front_out.filter_en, i[0]);
    end
    $display("test front controls done");
    read_start = 1; tick(1); read_start = 0; cmp(read_busy, 0);
    decim_factor = 16'h0000; tick(1); cmp(config_error, 1);
    arm = 1; tick(1); arm = 0; cmp(armed, 0);
    decim_factor = 16'h0004; post_count = 15'h4001; tick(1);
    cmp(config_error, 1);
    post_count = 15'h4000; record_len = 15'h0000; tick(1);
    cmp(config_error, 1);
    record_len = 15'h0008; tick(1);
    cmp(config_error, 0);
    decim_factor = 16'h0004; post_count = 15'h0010; arm = 1; tick(6);
    arm = 0; force_stop = 1; tick(1); force_stop = 0;
    cmp(armed, 0);
    cmp(capture_done, 0);
    cmp(triggered, 0);
    $display("test refusals done");
    capture(4, 10, 200); read_out(12, 8'h04, 10);
    $display("test decimation done");
    capture(1, 0, 20); cmp(oldest_ptr, 0); read_out(5, 8'h01, 0);
    $display("test zero post done");
    capture(1, 0, 17000); cmp(oldest_ptr != 14'h0000, 1); read_out(8, 8'h01, 0);
    $display("test ring wrap done");
    capture(1, 16384, 10); read_out(16384, 8'h01, 3);
    $display("test full post done");
    wrap_up();
  end
endmodule : tb
bind scope_capture_decimator scope_chk #(.DEPTH(DEPTH), .DECIM_B(DECIM_B)) scope_chk_i (.clk(clk),
  .arst_n(arst_n), .arm(arm), .force_stop(force_stop), .read_start(read_start), .front_cfg(front_cfg),
  .front_out(front_out), .armed(armed), .capture_done(capture_done), .config_error(config_error),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .read_busy(read_busy));
`default_nettype wire
